// [core/ecc_core.sv]
// Contract
// - current-address read starts at counter, no address
// - continue ack sends next sequential byte
// - address bytes load counter at ack
// - data byte ack increments counter by one
// - standby instead of ack keeps counter
// - no write unless latch set beforehand
// - page buffer holds up to 16 bytes
// - final ack after data starts write cycle
// - early final ack or standby: no write
// - write increments only low four bits
// - latch-set sets, latch-clear clears latch
// - latch command needs final ack, else idle
// - latch cleared at reset and after writes
// - status read answered even while busy
// - status layout: wip, latch, protect, zeros
// - wip flag follows internal write
// - latch bit changed only by latch commands, writes and reset
// - protect bits fixed at BP_RESET; no status write command
// - continue ack resends fresh status byte
// - read codes 0x06, 0x05, 0x03
// - write codes 0x6C, 0x96, 0x91
// - sequential read wraps to address zero
// - counter undefined until first load
`timescale 1ns/1ns
`default_nettype none
module ecc_core #(
    parameter int WRITE_CYCLES = ecc_pkg::WRITE_CYCLES,
    parameter int ADDR_W       = ecc_pkg::ADDR_W
) (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic        clkLink,
    input  wire logic        linkStartStb,
    input  wire logic        linkByteStb,
    input  wire logic [7:0]  linkByte,
    input  wire logic        linkAckStb,
    input  wire logic        linkAckCont,
    input  wire logic        linkStandbyStb,
    output logic      [7:0]  linkTxByte,
    output logic             linkTargetAck,
    output logic             linkIdle,
    output logic             writeBusy
);
    import ecc_pkg::*;
    localparam int MEM_BYTES = 1 << ADDR_W;
    localparam int TMR_W     = $clog2(WRITE_CYCLES + 1);
    // ************************************************************
    // link side event capture
    // ************************************************************
    ecc_ev_e          evKindL;
    logic [7:0]       evDataL;
    logic             evContL;
    logic             evTogL;
    // held until the next event; events are bit periods apart
    always_ff @(posedge clkLink or negedge rstn) begin
        if (!rstn) begin
            evKindL <= EV_STBY;
            evDataL <= 8'h00;
            evContL <= 1'b0;
            evTogL  <= 1'b0;
        end else if (linkStandbyStb) begin
            evKindL <= EV_STBY;
            evTogL  <= ~evTogL;
        end else if (linkStartStb) begin
            evKindL <= EV_START;
            evTogL  <= ~evTogL;
        end else if (linkAckStb) begin
            evKindL <= EV_ACK;
            evContL <= linkAckCont;
            evTogL  <= ~evTogL;
        end else if (linkByteStb) begin
            evKindL <= EV_BYTE;
            evDataL <= linkByte;
            evTogL  <= ~evTogL;
        end
    end

    // ************************************************************
    // event crossing into system clock
    // ************************************************************
    logic [2:0] evSync;
    logic       evFire;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            evSync <= 3'h0;
        end else begin
            evSync <= {evSync[1:0], evTogL};
        end
    end
    assign evFire = evSync[2] ^ evSync[1];
    wire logic isAck   = evFire && (evKindL == EV_ACK);
    wire logic isByte  = evFire && (evKindL == EV_BYTE);
    wire logic isStby  = evFire && (evKindL == EV_STBY);
    wire logic isStart = evFire && (evKindL == EV_START);
    wire logic isCont  = isAck && evContL;
    wire logic isFinal = isAck && !evContL;
    // ************************************************************
    // command state
    // ************************************************************
    ecc_state_e       state;
    logic [7:0]       cmd;
    logic [ADDR_W-1:0] addr;
    logic             write_enable_latch_bit;
    // protect bits are tied to BP_RESET inside this core, with no input
    wire logic [1:0]  bp = BP_RESET;
    logic             busy;
    logic             startWr;
    logic             gotByte;
    logic             anyData;
    logic [7:0]       txByte;
    logic             sakOk;
    logic             idleMode;
    logic             rspTog;
    logic [7:0]       page [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageMask;
    logic [7:0]       mem [MEM_BYTES];
    function automatic logic [ADDR_W-1:0] incAddr(
        input logic [ADDR_W-1:0] a
    );
        incAddr = a + {{(ADDR_W-1){1'b0}}, 1'b1};
    endfunction

    function automatic logic [ADDR_W-1:0] incPage(
        input logic [ADDR_W-1:0] a
    );
        incPage = {a[ADDR_W-1:PAGE_W],
                   a[PAGE_W-1:0] + {{(PAGE_W-1){1'b0}}, 1'b1}};
    endfunction

    wire logic [7:0] statusByte = {ST_UPPER, bp, write_enable_latch_bit, busy};
    wire logic arrayCmd = (evDataL == CMD_RANDOM_READ)
                       || (evDataL == CMD_CUR_READ)
                       || (evDataL == CMD_PAGE_WRITE);
    // counter has no reset: undefined until first load
    always_ff @(posedge clk_sys) begin
        if (state == S_ADDRH && isCont) begin
            addr <= {evDataL[ADDR_W-9:0], addr[7:0]};
        end else if (state == S_ADDRL && isCont) begin
            addr <= {addr[ADDR_W-1:8], evDataL};
        end else if (state == S_RDATA && isAck) begin
            addr <= incAddr(addr);
        end else if (state == S_WDATA && isAck && gotByte) begin
            addr <= incPage(addr);
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            write_enable_latch_bit <= 1'b0;
        end else if (state == S_CMDACK && isFinal
                     && cmd == CMD_LATCH_SET) begin
            write_enable_latch_bit <= 1'b1;
        end else if (state == S_CMDACK && isFinal
                     && cmd == CMD_LATCH_CLEAR) begin
            write_enable_latch_bit <= 1'b0;
        end else if (state == S_WDATA && isFinal && anyData) begin
            write_enable_latch_bit <= 1'b0;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (state == S_WDATA && isByte) begin
            page[addr[PAGE_W-1:0]] <= evDataL;
        end
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state    <= S_IDLE;
            cmd      <= 8'h00;
            gotByte  <= 1'b0;
            anyData  <= 1'b0;
            pageMask <= '0;
            startWr  <= 1'b0;
            txByte   <= 8'h00;
            sakOk    <= 1'b0;
            idleMode <= 1'b1;
        end else begin
            startWr <= 1'b0;
            if (isStby) begin
                // standby drops any unfinished page write
                state    <= S_IDLE;
                idleMode <= 1'b1;
                sakOk    <= 1'b0;
            end else if (isStart) begin
                state    <= S_CMD;
                idleMode <= 1'b0;
                sakOk    <= 1'b1;
            end else if (!idleMode) begin
                case (state)
                    S_CMD: begin
                        if (isByte) begin
                            cmd <= evDataL;
                            if (busy && arrayCmd) begin
                                idleMode <= 1'b1;
                                sakOk    <= 1'b0;
                                state    <= S_IDLE;
                            end else if (evDataL == CMD_STAT_READ) begin
                                txByte <= statusByte;
                                state  <= S_STAT;
                            end else if (arrayCmd
                                || evDataL == CMD_LATCH_SET
                                || evDataL == CMD_LATCH_CLEAR) begin
                                state <= S_CMDACK;
                            end else begin
                                idleMode <= 1'b1;
                                sakOk    <= 1'b0;
                                state    <= S_IDLE;
                            end
                        end
                    end
                    S_CMDACK: begin
                        if (isFinal) begin
                            state <= S_IDLE;
                        end else if (isCont) begin
                            if (cmd == CMD_LATCH_SET
                                || cmd == CMD_LATCH_CLEAR) begin
                                idleMode <= 1'b1;
                                sakOk    <= 1'b0;
                                state    <= S_IDLE;
                            end else if (cmd == CMD_CUR_READ) begin
                                txByte <= mem[addr];
                                state  <= S_RDATA;
                            end else begin
                                state <= S_ADDRH;
                            end
                        end
                    end
                    S_ADDRH: begin
                        if (isCont) begin
                            state <= S_ADDRL;
                        end else if (isFinal) begin
                            state <= S_IDLE;
                        end
                    end
                    S_ADDRL: begin
                        if (isCont && cmd == CMD_PAGE_WRITE) begin
                            state    <= S_WDATA;
                            gotByte  <= 1'b0;
                            anyData  <= 1'b0;
                            pageMask <= '0;
                        end else if (isCont) begin
                            txByte <= mem[{addr[ADDR_W-1:8], evDataL}];
                            state  <= S_RDATA;
                        end else if (isFinal) begin
                            state <= S_IDLE;
                        end
                    end
                    S_RDATA: begin
                        if (isCont) begin
                            txByte <= mem[incAddr(addr)];
                        end else if (isFinal) begin
                            state <= S_IDLE;
                        end
                    end
                    S_WDATA: begin
                        if (isByte) begin
                            gotByte <= 1'b1;
                            anyData <= 1'b1;
                            pageMask[addr[PAGE_W-1:0]] <= 1'b1;
                        end else if (isCont) begin
                            gotByte <= 1'b0;
                        end else if (isFinal) begin
                            gotByte <= 1'b0;
                            state   <= S_IDLE;
                            startWr <= anyData && write_enable_latch_bit;
                        end
                    end
                    S_STAT: begin
                        if (isCont) begin
                            txByte <= statusByte;
                        end else if (isFinal) begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end
    // ************************************************************
    // internal write cycle
    // ************************************************************
    logic [TMR_W-1:0]        wrTmr;
    logic [ADDR_W-PAGE_W-1:0] wrBase;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy   <= 1'b0;
            wrTmr  <= '0;
            wrBase <= '0;
        end else if (startWr) begin
            busy   <= 1'b1;
            wrTmr  <= TMR_W'(WRITE_CYCLES);
            wrBase <= addr[ADDR_W-1:PAGE_W];
        end else if (busy && wrTmr == '0) begin
            busy <= 1'b0;
        end else if (busy) begin
            wrTmr <= wrTmr - {{(TMR_W-1){1'b0}}, 1'b1};
        end
    end
    // the loaded page bytes (pageMask) land at the end, as one cell program
    always_ff @(posedge clk_sys) begin
        if (busy && wrTmr == '0) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pageMask[i]) begin
                    mem[{wrBase, PAGE_W'(i)}] <= page[i];
                end
            end
        end
    end
    assign writeBusy = busy;
    // ************************************************************
    // answer crossing back to the link
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rspTog <= 1'b0;
        end else if (evFire) begin
            rspTog <= ~rspTog;
        end
    end
    logic [2:0] rspSync;
    always_ff @(posedge clkLink or negedge rstn) begin
        if (!rstn) begin
            rspSync <= 3'h0;
        end else begin
            rspSync <= {rspSync[1:0], rspTog};
        end
    end
    // answer fields are stable once the toggle has crossed
    always_ff @(posedge clkLink or negedge rstn) begin
        if (!rstn) begin
            linkTxByte    <= 8'h00;
            linkTargetAck <= 1'b0;
            linkIdle      <= 1'b1;
        end else if (rspSync[2] ^ rspSync[1]) begin
            linkTxByte    <= txByte;
            linkTargetAck <= sakOk;
            linkIdle      <= idleMode;
        end
    end
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    sequence latchCmdAck(logic [7:0] c);
        state == S_CMDACK && cmd == c && isAck;
    endsequence
    a_latch_set: assert property (
        latchCmdAck(CMD_LATCH_SET) and isFinal |=> write_enable_latch_bit
    ) else $error("latch not set by latch-set command");
    a_latch_clear: assert property (
        latchCmdAck(CMD_LATCH_CLEAR) and isFinal |=> !write_enable_latch_bit
    ) else $error("latch not cleared by latch-clear command");
    a_latch_mak: assert property (
        latchCmdAck(CMD_LATCH_SET) and isCont
        |=> idleMode && !sakOk && write_enable_latch_bit == $past(write_enable_latch_bit)
    ) else $error("latch command with continue ack executed");
    a_write_needs_wel: assert property (
        $rose(busy) |-> $past(write_enable_latch_bit, 2)
    ) else $error("write cycle started without latch");
    a_wel_after_write: assert property (
        $rose(busy) |-> !write_enable_latch_bit
    ) else $error("latch still set after write start");
    a_early_final: assert property (
        state == S_WDATA && isFinal && !anyData && !busy
        |=> !startWr ##1 !busy
    ) else $error("write started with no data");
    a_read_incr: assert property (
        state == S_RDATA && isAck |=> addr == incAddr($past(addr))
    ) else $error("read counter not incremented by one");
    a_page_wrap: assert property (
        state == S_WDATA && isAck && gotByte
        |=> addr[ADDR_W-1:PAGE_W] == $past(addr[ADDR_W-1:PAGE_W])
            && addr[PAGE_W-1:0] == $past(addr[PAGE_W-1:0]) + 4'h1
    ) else $error("page write counter crossed page");
    a_stby_hold: assert property (
        isStby && state != S_ADDRH && state != S_ADDRL
        |=> addr == $past(addr)
    ) else $error("counter changed on standby");
    a_status_fresh: assert property (
        state == S_STAT && isCont
        |=> txByte == {ST_UPPER, $past(bp), $past(write_enable_latch_bit), $past(busy)}
    ) else $error("resent status byte is stale");
    a_status_upper: assert property (
        state == S_CMD && isByte && evDataL == CMD_STAT_READ && !idleMode
        |=> txByte[7:4] == ST_UPPER && txByte[ST_WIP_BIT] == $past(busy)
            && txByte[ST_WEL_BIT] == $past(write_enable_latch_bit)
    ) else $error("status byte layout wrong");
endmodule
`default_nettype wire

// [core/ecc_pkg.sv]
`default_nettype none
package ecc_pkg;
    // ************************************************************
    // command codes
    // ************************************************************
    localparam logic [7:0] CMD_RANDOM_READ = 8'h03;
    localparam logic [7:0] CMD_CUR_READ    = 8'h06;
    localparam logic [7:0] CMD_STAT_READ   = 8'h05;
    localparam logic [7:0] CMD_PAGE_WRITE  = 8'h6C;
    localparam logic [7:0] CMD_LATCH_SET   = 8'h96;
    localparam logic [7:0] CMD_LATCH_CLEAR = 8'h91;
    // ************************************************************
    // status byte layout
    // ************************************************************
    localparam int         ST_WIP_BIT  = 0;
    localparam int         ST_WEL_BIT  = 1;
    localparam int         ST_BP_LO    = 2;
    localparam int         ST_BP_HI    = 3;
    localparam logic [3:0] ST_UPPER    = 4'h0;
    localparam logic [1:0] BP_RESET    = 2'h0;
    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int         ADDR_W      = 11;
    localparam int         PAGE_BYTES  = 16;
    localparam int         PAGE_W      = 4;
    localparam int         WRITE_CYCLES = 1000;
    // ************************************************************
    // link events and command states
    // ************************************************************
    typedef enum logic [1:0] {
        EV_START = 2'h0,
        EV_BYTE  = 2'h1,
        EV_ACK   = 2'h2,
        EV_STBY  = 2'h3
    } ecc_ev_e;
    typedef enum logic [7:0] {
        S_IDLE   = 8'h01,
        S_CMD    = 8'h02,
        S_CMDACK = 8'h04,
        S_ADDRH  = 8'h08,
        S_ADDRL  = 8'h10,
        S_WDATA  = 8'h20,
        S_RDATA  = 8'h40,
        S_STAT   = 8'h80
    } ecc_state_e;
endpackage
`default_nettype wire

// [dv/ecc_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ecc_host_model (
    input  wire logic        clkLink,
    output var  logic        linkStartStb,
    output var  logic        linkByteStb,
    output var  logic [7:0]  linkByte,
    output var  logic        linkAckStb,
    output var  logic        linkAckCont,
    output var  logic        linkStandbyStb
);
    import ecc_pkg::*;
    // ************************************************************
    // host event driver
    // ************************************************************
    // gap of 8 or more keeps events from being lost across the crossing
    int gap = 10;

    initial begin
        linkStartStb   = 1'b0;
        linkByteStb    = 1'b0;
        linkByte       = 8'h00;
        linkAckStb     = 1'b0;
        linkAckCont    = 1'b0;
        linkStandbyStb = 1'b0;
    end

    task automatic pulse(input ecc_ev_e k, input logic [7:0] b,
                         input logic c);
        @(posedge clkLink);
        linkStartStb   <= (k == EV_START);
        linkByteStb    <= (k == EV_BYTE);
        linkAckStb     <= (k == EV_ACK);
        linkStandbyStb <= (k == EV_STBY);
        linkByte       <= b;
        linkAckCont    <= c;
        @(posedge clkLink);
        linkStartStb   <= 1'b0;
        linkByteStb    <= 1'b0;
        linkAckStb     <= 1'b0;
        linkStandbyStb <= 1'b0;
        // released lines show inverted data, never a stale value
        linkByte       <= ~b;
        linkAckCont    <= ~c;
        repeat (gap - 1) @(posedge clkLink);
    endtask

    // page write: command, high then low address, data, acks
    task automatic wr(input logic [7:0] hi, input logic [7:0] lo,
                      input logic [7:0] dat [4], input int n,
                      input logic fin);
        pulse(EV_START, 8'h00, 1'b0);
        pulse(EV_BYTE, CMD_PAGE_WRITE, 1'b0);
        pulse(EV_ACK, 8'h00, 1'b1);
        pulse(EV_BYTE, hi, 1'b0);
        pulse(EV_ACK, 8'h00, 1'b1);
        pulse(EV_BYTE, lo, 1'b0);
        pulse(EV_ACK, 8'h00, 1'b1);
        // caller keeps lo + n inside one page unless testing the wrap
        for (int i = 0; i < n; i++) begin
            pulse(EV_BYTE, dat[i], 1'b0);
            if (i == n - 1 && !fin) begin
                pulse(EV_STBY, 8'h00, 1'b0);
            end else begin
                pulse(EV_ACK, 8'h00, i != n - 1);
            end
        end
    endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ecc_pkg::*;
    // ************************************************************
    // clocks, reset, instances
    // ************************************************************
    localparam int WCYC = 400;
    logic        clk_sys;
    logic        rstn;
    logic        clkLink;
    wire logic   linkStartStb;
    wire logic   linkByteStb;
    wire logic [7:0] linkByte;
    wire logic   linkAckStb;
    wire logic   linkAckCont;
    wire logic   linkStandbyStb;
    wire logic [7:0] linkTxByte;
    wire logic   linkTargetAck;
    wire logic   linkIdle;
    wire logic   writeBusy;
    int          errTotal = 0;
    int          testsRun = 0;
    int          kindQ[$];
    logic [7:0]  valQ[$];
    logic [7:0]  dat [4];

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        clkLink = 1'b0;
        #5;
        forever #24 clkLink = ~clkLink;
    end

    ecc_core #(.WRITE_CYCLES(WCYC)) ecc_core_i (
        .clk_sys(clk_sys), .rstn(rstn), .clkLink(clkLink),
        .linkStartStb(linkStartStb), .linkByteStb(linkByteStb),
        .linkByte(linkByte), .linkAckStb(linkAckStb),
        .linkAckCont(linkAckCont), .linkStandbyStb(linkStandbyStb),
        .linkTxByte(linkTxByte), .linkTargetAck(linkTargetAck),
        .linkIdle(linkIdle), .writeBusy(writeBusy));
    ecc_host_model ecc_host_model_i (
        .clkLink(clkLink), .linkStartStb(linkStartStb),
        .linkByteStb(linkByteStb), .linkByte(linkByte),
        .linkAckStb(linkAckStb), .linkAckCont(linkAckCont),
        .linkStandbyStb(linkStandbyStb));
    // ************************************************************
    // scoreboard
    // ************************************************************
    task automatic finishTest;
        $display("checks=%0d mismatches=%0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] expv);
        testsRun++;
        if (seen !== expv) begin
            errTotal++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    // kind: 0 tx byte, 1 target ack, 2 idle, 3 busy, 4 wip bit of tx
    task automatic expect_out(input int k, input logic [7:0] v);
        #1;
        kindQ.push_back(k);
        valQ.push_back(v);
    endtask

    initial begin
        int         k;
        logic [7:0] seen;
        forever begin
            wait (kindQ.size() != 0);
            k = kindQ.pop_front();
            case (k)
                0:       seen = linkTxByte;
                1:       seen = {7'h00, linkTargetAck};
                2:       seen = {7'h00, linkIdle};
                3:       seen = {7'h00, writeBusy};
                default: seen = {7'h00, linkTxByte[0]};
            endcase
            check(seen, valQ.pop_front());
        end
    end

    initial begin
        #500000;
        errTotal++;
        finishTest();
    end
    // ************************************************************
    // link helpers
    // ************************************************************
    task automatic ev(input ecc_ev_e k, input logic [7:0] b, input logic c);
        ecc_host_model_i.pulse(k, b, c);
    endtask
    task automatic open(input logic [7:0] code);
        ev(EV_START, 8'h00, 1'b0);
        ev(EV_BYTE, code, 1'b0);
    endtask
    task automatic latch(input logic [7:0] code);
        open(code);
        ev(EV_ACK, 8'h00, 1'b0);
    endtask
    task automatic status(input logic [7:0] e);
        open(CMD_STAT_READ);
        expect_out(0, e);
        expect_out(1, 8'h01);
        ev(EV_ACK, 8'h00, 1'b0);
    endtask
    // load counter through random-read address bytes, then abandon
    task automatic setaddr(input logic [7:0] hi, input logic [7:0] lo);
        open(CMD_RANDOM_READ);
        ev(EV_ACK, 8'h00, 1'b1);
        ev(EV_BYTE, hi, 1'b0);
        ev(EV_ACK, 8'h00, 1'b1);
        ev(EV_BYTE, lo, 1'b0);
        ev(EV_ACK, 8'h00, 1'b1);
        ev(EV_STBY, 8'h00, 1'b0);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        rstn = 1'b0;
        void'($urandom(92976));
        for (int i = 0; i < 4; i++) begin
            dat[i] = 8'($urandom);
        end
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clkLink);
        expect_out(2, 8'h01);
        // counter is unknown until loaded; load it before any standby
        setaddr(8'h01, 8'h2E);
        status(8'h00);
        latch(CMD_LATCH_SET);
        status(8'h02);
        latch(CMD_LATCH_CLEAR);
        status(8'h00);
        open(CMD_LATCH_SET);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(2, 8'h01);
        expect_out(1, 8'h00);
        ev(EV_STBY, 8'h00, 1'b0);
        status(8'h00);
        ecc_host_model_i.wr(8'h01, 8'h2E, dat, 3, 1'b1);
        expect_out(3, 8'h00);
        latch(CMD_LATCH_SET);
        ecc_host_model_i.wr(8'h01, 8'h2E, dat, 2, 1'b0);
        expect_out(3, 8'h00);
        latch(CMD_LATCH_SET);
        ecc_host_model_i.wr(8'h01, 8'h2E, dat, 3, 1'b1);
        expect_out(3, 8'h01);
        open(CMD_STAT_READ);
        expect_out(4, 8'h01);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(4, 8'h01);
        // busy window is WCYC + 1 system cycles, about 67 link cycles
        repeat (60) @(posedge clkLink);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(0, 8'h00);
        ev(EV_ACK, 8'h00, 1'b0);
        ecc_host_model_i.gap = 13;
        setaddr(8'h01, 8'h2E);
        open(CMD_CUR_READ);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(0, dat[0]);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(0, dat[1]);
        ev(EV_STBY, 8'h00, 1'b0);
        open(CMD_CUR_READ);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(0, dat[1]);
        ev(EV_ACK, 8'h00, 1'b0);
        setaddr(8'h01, 8'h20);
        open(CMD_CUR_READ);
        ev(EV_ACK, 8'h00, 1'b1);
        expect_out(0, dat[2]);
        ev(EV_ACK, 8'h00, 1'b0);
        #1;
        wait (kindQ.size() == 0);
        finishTest();
    end
endmodule
`default_nettype wire
